// file: ubt_regs.svh
// constants for the universal bus transceiver data path
// How it works
// - rising clock with enables low stores data
// - no clock edge keeps stored value
// - clock enable high ignores clock edges
// - b-to-a mirrors all five modes
`ifndef UNB_REGS_SVH
`define UNB_REGS_SVH
`define UNB_WIDTH      18
`define UNB_FIFO_DEPTH 8
`define UNB_DATA_RESET 18'h0_0000
`define UNB_OE_RESET   1'b1
`endif

// file: ubt_pkg.sv
// types shared by the transceiver design
`default_nettype none
package unb_pkg;
	typedef struct packed {
		logic output_enable_n;
		logic latch_enable;
		logic clock;
		logic clock_enable_n;
	} unb_ctrl_s;
	typedef enum logic [4:0] {
		UNB_ISOLATE  = 5'b00001,
		UNB_TRANSP   = 5'b00010,
		UNB_CLOCKED  = 5'b00100,
		UNB_HOLD     = 5'b01000,
		UNB_INHIBIT  = 5'b10000
	} unb_mode_e;
endpackage
`default_nettype wire

// file: ubt_transceiver.sv
// transceiver data path: two directions, each with a stored word and a fifo
`timescale 1ns/1ns
`default_nettype none
`include "ubt_regs.svh"

// ------------------------------------------------------------
// word fifo between the loading side and the output register
// ------------------------------------------------------------
module unb_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	// ------------------------------------------------------------
	// pointer wrap
	// ------------------------------------------------------------
	// wrap is spelled out so a depth that is not a power of two still works
	function automatic logic [AW-1:0] ptr_step(input logic [AW-1:0] p);
		if (p == AW'(DEPTH - 1)) begin
			return '0;
		end else begin
			return p + 1'b1;
		end
	endfunction

	// ------------------------------------------------------------
	// storage and state
	// ------------------------------------------------------------
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             push;
	logic             pop;

	// ------------------------------------------------------------
	// handshake
	// ------------------------------------------------------------
	// full is the count reaching depth, not the pointers meeting
	assign in_ready  = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr];

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count  = count;
		if (push) begin
			next_wr_ptr = ptr_step(wr_ptr);
		end
		if (pop) begin
			next_rd_ptr = ptr_step(rd_ptr);
		end
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// storage has no reset: only words behind a valid count are read
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end
endmodule

// ------------------------------------------------------------
// two-direction transceiver core
// ------------------------------------------------------------
module unb_transceiver
	import unb_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   rstn,
	input  wire unb_ctrl_s              a_to_b_ctrl,
	input  wire unb_ctrl_s              b_to_a_ctrl,
	input  wire logic [`UNB_WIDTH-1:0]  a_in,
	input  wire logic [`UNB_WIDTH-1:0]  b_in,
	output logic      [`UNB_WIDTH-1:0]  a_out,
	output logic                        a_oe_n,
	output logic      [`UNB_WIDTH-1:0]  b_out,
	output logic                        b_oe_n,
	output logic                        a_to_b_ready,
	output logic                        b_to_a_ready,
	output unb_mode_e                   a_to_b_mode,
	output unb_mode_e                   b_to_a_mode
);
	// ------------------------------------------------------------
	// mode decoding
	// ------------------------------------------------------------
	function automatic unb_mode_e decode_mode(input unb_ctrl_s c, input logic rise);
		if (c.output_enable_n) begin
			return UNB_ISOLATE;
		end else if (c.latch_enable) begin
			return UNB_TRANSP;
		end else if (c.clock_enable_n) begin
			return UNB_INHIBIT;
		end else if (rise) begin
			return UNB_CLOCKED;
		end else begin
			return UNB_HOLD;
		end
	endfunction

	// ------------------------------------------------------------
	// direction bundles
	// ------------------------------------------------------------
	// index 0 carries a-to-b, index 1 carries b-to-a
	unb_ctrl_s             ctrl       [2];
	logic [`UNB_WIDTH-1:0] din        [2];
	logic [`UNB_WIDTH-1:0] dout       [2];
	logic                  oe_n       [2];
	logic                  rdy        [2];
	logic                  fifo_ready [2];
	unb_mode_e             mode       [2];

	assign ctrl[0] = a_to_b_ctrl;
	assign ctrl[1] = b_to_a_ctrl;
	assign din[0]  = a_in;
	assign din[1]  = b_in;

	// ------------------------------------------------------------
	// per-direction path
	// ------------------------------------------------------------
	// identical path per direction
	for (genvar d = 0; d < 2; d++) begin : g_dir
		logic                  clk_prev;
		logic                  rise;
		logic                  load;
		logic                  f_valid;
		logic [`UNB_WIDTH-1:0] f_data;

		assign rise    = ctrl[d].clock && !clk_prev;
		assign mode[d] = decode_mode(ctrl[d], rise);
		assign load    = (mode[d] == UNB_CLOCKED) || (mode[d] == UNB_TRANSP);
		// output register drains every cycle, so the fifo never backs up
		assign rdy[d]  = 1'b1;

		// parked high, so a clock resting high after reset is no edge
		always_ff @(posedge clk) begin
			if (!rstn) begin
				clk_prev <= 1'b1;
			end else begin
				clk_prev <= ctrl[d].clock;
			end
		end

		unb_fifo #(
			.WIDTH (`UNB_WIDTH),
			.DEPTH (`UNB_FIFO_DEPTH)
		) u_fifo (
			.clk       (clk),
			.rstn      (rstn),
			.in_valid  (load),
			.in_ready  (fifo_ready[d]),
			.in_data   (din[d]),
			.out_valid (f_valid),
			.out_ready (rdy[d]),
			.out_data  (f_data)
		);

		always_ff @(posedge clk) begin
			if (!rstn) begin
				dout[d] <= `UNB_DATA_RESET;
			end else if (f_valid) begin
				dout[d] <= f_data;
			end
		end

		always_ff @(posedge clk) begin
			if (!rstn) begin
				oe_n[d] <= `UNB_OE_RESET;
			end else begin
				oe_n[d] <= ctrl[d].output_enable_n;
			end
		end
	end

	// ------------------------------------------------------------
	// pin mapping
	// ------------------------------------------------------------
	assign b_out        = dout[0];
	assign b_oe_n       = oe_n[0];
	assign a_out        = dout[1];
	assign a_oe_n       = oe_n[1];
	assign a_to_b_ready = fifo_ready[0];
	assign b_to_a_ready = fifo_ready[1];
	assign a_to_b_mode  = mode[0];
	assign b_to_a_mode  = mode[1];
endmodule
`default_nettype wire

// file: ubt_transceiver_asserts.sv
// checker for the transceiver data path
`timescale 1ns/1ns
`default_nettype none
module unb_asserts
	import unb_pkg::*;
(
	input wire logic        clk,
	input wire logic        rstn,
	input wire unb_ctrl_s   a_to_b_ctrl,
	input wire unb_ctrl_s   b_to_a_ctrl,
	input wire logic [17:0] a_in,
	input wire logic [17:0] b_in,
	input wire logic [17:0] a_out,
	input wire logic [17:0] b_out,
	input wire logic        a_oe_n,
	input wire logic        b_oe_n,
	input wire logic        a_to_b_ready,
	input wire logic        b_to_a_ready,
	input wire unb_mode_e   a_to_b_mode,
	input wire unb_mode_e   b_to_a_mode
);
	wire unb_ctrl_s f = a_to_b_ctrl;
	wire unb_ctrl_s r = b_to_a_ctrl;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_clk; !f.clock_enable_n && !f.output_enable_n && !f.latch_enable
		&& $rose(f.clock) && a_to_b_ready |-> ##2 b_out == $past(a_in, 2); endproperty
	a_clk: assert property (p_clk) else $error("clocked word lost");
	property p_hold; (!f.output_enable_n && !f.latch_enable && !f.clock_enable_n
		&& !$rose(f.clock))[*3] |-> $stable(b_out); endproperty
	a_hold: assert property (p_hold) else $error("stored word moved");
	property p_inh; (f.clock_enable_n && !f.output_enable_n && !f.latch_enable)[*3]
		|-> $stable(b_out); endproperty
	a_inh: assert property (p_inh) else $error("inhibit ignored");
	property p_ba; !r.output_enable_n && r.latch_enable && b_to_a_ready
		|-> ##2 a_out == $past(b_in, 2); endproperty
	a_ba: assert property (p_ba) else $error("reverse path wrong");
	property p_tr; !f.output_enable_n && f.latch_enable && a_to_b_ready
		|-> ##2 b_out == $past(a_in, 2); endproperty
	a_tr: assert property (p_tr) else $error("transparent path wrong");
	property p_oe; 1'b1 |=> b_oe_n == $past(f.output_enable_n); endproperty
	a_oe: assert property (p_oe) else $error("enable not followed");
	property p_ba_clk; !r.clock_enable_n && !r.output_enable_n && !r.latch_enable
		&& $rose(r.clock) && b_to_a_ready |-> ##2 a_out == $past(b_in, 2); endproperty
	a_ba_clk: assert property (p_ba_clk) else $error("reverse clocked word lost");
	property p_ba_oe; 1'b1 |=> a_oe_n == $past(r.output_enable_n); endproperty
	a_ba_oe: assert property (p_ba_oe) else $error("reverse enable not followed");
	property p_iso; f.output_enable_n && r.output_enable_n
		|-> a_to_b_mode == UNB_ISOLATE && b_to_a_mode == UNB_ISOLATE; endproperty
	a_iso: assert property (p_iso) else $error("isolation not decoded");
endmodule
bind unb_transceiver unb_asserts chk_u (.clk, .rstn, .a_to_b_ctrl, .b_to_a_ctrl, .a_in,
	.b_in, .a_out, .b_out, .a_oe_n, .b_oe_n, .a_to_b_ready, .b_to_a_ready,
	.a_to_b_mode, .b_to_a_mode);
`default_nettype wire

// file: ubt_card.sv
// card-side control model for one direction
`timescale 1ns/1ns
`default_nettype none
module unb_card
	import unb_pkg::*;
(
	input  wire logic      clk,
	input  wire unb_mode_e mode,
	output var  unb_ctrl_s ctrl = '{1'b1, 1'b0, 1'b1, 1'b0}
);
	// clock parked high before latch drops
	always @(posedge clk) begin
		case (mode)
			UNB_ISOLATE: ctrl <= '{1'b1, 1'b0, ctrl.clock, 1'b0};
			UNB_TRANSP: ctrl <= '{1'b0, 1'b1, 1'b1, 1'b0};
			UNB_CLOCKED: ctrl <= '{1'b0, 1'b0, ~ctrl.clock, 1'b0};
			UNB_HOLD: ctrl <= '{1'b0, 1'b0, 1'b1, 1'b0};
			default: ctrl <= '{1'b0, 1'b0, ~ctrl.clock, 1'b1};
		endcase
	end
endmodule
`default_nettype wire

// file: tb_universal_bus_transceiver.sv
// self-checking bench for the transceiver data path
`timescale 1ns/1ns
`default_nettype none
module tb_universal_bus_transceiver
	import unb_pkg::*;
;
	logic        clk     = 1'b0;
	logic        rstn    = 1'b0;
	logic [17:0] a_in    = 18'h0_0000;
	logic [17:0] b_in    = 18'h0_0000;
	logic [17:0] a_out;
	logic [17:0] b_out;
	logic        a_oe_n;
	logic        b_oe_n;
	unb_mode_e   m_ab    = UNB_ISOLATE;
	unb_mode_e   m_ba    = UNB_ISOLATE;
	unb_ctrl_s   c_ab;
	unb_ctrl_s   c_ba;
	int          n_fail  = 0;
	int          n_tests = 0;
	always #5 clk = ~clk;
	unb_card ca (.clk, .mode(m_ab), .ctrl(c_ab));
	unb_card cb (.clk, .mode(m_ba), .ctrl(c_ba));
	unb_transceiver dut_u (.clk, .rstn, .a_to_b_ctrl(c_ab), .b_to_a_ctrl(c_ba), .a_in,
		.b_in, .a_out, .a_oe_n, .b_out, .b_oe_n, .a_to_b_ready(), .b_to_a_ready(),
		.a_to_b_mode(), .b_to_a_mode());
	task automatic chk(input logic [17:0] exp, input logic [17:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t exp %h got %h", $time, exp, got);
		end
	endtask
	// modes move first; data follows once the card has applied them
	task automatic go(input unb_mode_e ab, input unb_mode_e ba, input logic [17:0] da,
		input logic [17:0] db);
		m_ab = ab;
		m_ba = ba;
		repeat (2) @(posedge clk);
		#1;
		a_in = da;
		b_in = db;
		repeat (8) @(posedge clk);
		#1;
	endtask
	task automatic t_transp;
		go(UNB_TRANSP, UNB_TRANSP, 18'h1_2345, 18'h2_0a5c);
		chk(18'h1_2345, b_out);
		chk(18'h2_0a5c, a_out);
		chk(18'h0_0000, {17'h0_0000, b_oe_n});
		chk(18'h0_0000, {17'h0_0000, a_oe_n});
	endtask
	task automatic t_hold;
		go(UNB_HOLD, UNB_HOLD, 18'h0_0f0f, 18'h3_3333);
		chk(18'h1_2345, b_out);
		chk(18'h2_0a5c, a_out);
	endtask
	task automatic t_clocked;
		go(UNB_CLOCKED, UNB_CLOCKED, 18'h2_aaaa, 18'h0_c3c3);
		chk(18'h2_aaaa, b_out);
		chk(18'h0_c3c3, a_out);
	endtask
	task automatic t_inhibit;
		go(UNB_INHIBIT, UNB_INHIBIT, 18'h1_5555, 18'h0_1111);
		chk(18'h2_aaaa, b_out);
		chk(18'h0_c3c3, a_out);
	endtask
	// a reset in mid-run clears both words and floats the b port
	task automatic t_reset;
		go(UNB_TRANSP, UNB_TRANSP, 18'h3_c0de, 18'h1_0f0f);
		chk(18'h3_c0de, b_out);
		rstn = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk(18'h0_0000, b_out);
		chk(18'h0_0000, a_out);
		chk(18'h0_0001, {17'h0_0000, b_oe_n});
		rstn = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk(18'h3_c0de, b_out);
		chk(18'h1_0f0f, a_out);
	endtask
	task automatic t_isolate;
		go(UNB_ISOLATE, UNB_ISOLATE, 18'h0_0000, 18'h0_0000);
		chk(18'h0_0001, {17'h0_0000, b_oe_n});
		chk(18'h0_0001, {17'h0_0000, a_oe_n});
	endtask
	task automatic tally_and_finish;
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		#3000;
		n_fail++;
		tally_and_finish();
	end
	initial begin
		repeat (20) @(posedge clk);
		#1;
		rstn = 1'b1;
		t_transp();
		t_hold();
		t_clocked();
		t_inhibit();
		t_reset();
		t_isolate();
		tally_and_finish();
	end
endmodule
`default_nettype wire
